// ===== bdbt_term.sv
// Data-beat and data-tenure termination for the external system bus.
// Assumes bus pins arrive asynchronously and a core that queues one request.
//
// How it works
// [R1] - An acknowledge ends the current beat next cycle and advances bursts.
// [R2] - An acknowledge on the last beat also closes a write tenure next cycle, a read tenure a cycle later if not retried.
// [R3] - Target acks with valid data except on a read beat it then retries; data is valid in a retry's last cycle.
// [R4] - With acknowledge negated the beat stays open as wait states.
// [R5] - Target may withhold acknowledge during retry except its last cycle.
// [R6] - Acknowledge only inside the tenure, not two cycles before address retry.
// [R7] - In bursts the target drops acknowledge next cycle unless acking again.
// [R8] - System negates acknowledge and error before the next tenure starts.
// [R9] - Target leaves the required wait states before the first burst ack.
// [R10] - Read retry discards the previous beat and waits for a fresh ack.
// [R11] - Retry after the last beat keeps the tenure alive though busy dropped.
// [R12] - Retry input is ignored as termination control on writes.
// [R13] - Target asserts retry after the ack and holds it until valid data.
// [R14] - Target negates retry the cycle after valid data with acknowledge.
// [R15] - Retry pin level at hard reset release selects the retry mode.
// [R16] - Error acknowledge ends the tenure next cycle and raises machine check.
// [R17] - Error acknowledge does not cancel read data already being delivered.
// [R18] - Target holds error acknowledge one cycle, within the tenure.
// [R19] - Data bus is released the cycle after the final ack or an error.
// [R20] - One beat for single transfers, four beats for line bursts.
// [R21] - Busy is driven the cycle after a qualified grant, until the last ack or an error.
// [R22] - Committed beats are counted; a retried beat does not advance it.
`timescale 1ns/1ps
module bdbt_term (
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	// Bus pins; control levels active low, output enables active high; inputs from outside the clock domain
	input  wire logic         transfer_ack_n_i,
	input  wire logic         beat_retry_in_n_i,
	input  wire logic         bus_error_ack_n_i,
	input  wire logic         dbus_grant_n_i,
	input  wire logic         dbus_busy_n_i,
	input  wire logic         addr_retry_n_i,
	input  wire logic         hard_reset_n_i,
	input  wire logic [63:0]  data_i,
	output logic [63:0]       data_o,
	output logic              data_oe_o,
	output logic              dbus_busy_n_o,
	output logic              dbus_busy_oe_o,
	// Core side
	input  wire logic         req_valid_i,
	input  wire logic         req_write_i,
	input  wire logic         req_burst_i,
	output logic              req_ready_o,
	input  wire logic [63:0]  wr_data_i,
	output logic              wr_take_o,
	output logic              rd_valid_o,
	input  wire logic         rd_ready_i,
	output logic [63:0]       rd_data_o,
	output logic              tenure_done_o,
	output logic              mcheck_o,
	output logic              no_retry_mode_o
);
	////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	bdbt_pkg::bdbt_pins_s  pins_meta;
	bdbt_pkg::bdbt_pins_s  pins;
	logic [63:0]           data_meta;
	logic [63:0]           data_s;

	// Data passes the same two stages so it stays aligned with acknowledge
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pins_meta <= '1;
			pins      <= '1;
			// Hard reset reads as asserted until the pin is really sampled, so the
			// strap is also caught on the first release after rst_i
			pins_meta.hard_reset_n <= ~bdbt_pkg::PIN_IDLE_N; // [R15]
			pins.hard_reset_n      <= ~bdbt_pkg::PIN_IDLE_N;
			data_meta <= '0;
			data_s    <= '0;
		end else begin
			pins_meta <= {transfer_ack_n_i, beat_retry_in_n_i, bus_error_ack_n_i,
			              dbus_grant_n_i, dbus_busy_n_i, addr_retry_n_i, hard_reset_n_i};
			pins      <= pins_meta;
			data_meta <= data_i;
			data_s    <= data_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Retry mode strap

	logic hres_prev;
	logic retry_mode;
	logic next_retry_mode;

	// Caught on the rising edge of the synchronised hard reset
	// Limitation: a strap change while hard reset is held counts only at release
	always_comb begin
		next_retry_mode = retry_mode;
		if (!hres_prev && pins.hard_reset_n) begin
			next_retry_mode = pins.retry_n; // [R15]
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			hres_prev       <= bdbt_pkg::PIN_IDLE_N;
			retry_mode      <= bdbt_pkg::RETRY_MODE_RST;
			no_retry_mode_o <= ~bdbt_pkg::RETRY_MODE_RST;
		end else begin
			hres_prev       <= pins.hard_reset_n;
			retry_mode      <= next_retry_mode;
			no_retry_mode_o <= ~next_retry_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Tenure state machine

	bdbt_pkg::bdbt_state_e state;
	bdbt_pkg::bdbt_state_e next_state;
	logic        is_write;
	logic        next_is_write;
	logic [2:0]  beats;
	logic [2:0]  next_beats;
	logic [2:0]  cnt;
	logic [2:0]  next_cnt;
	logic        stage_v;
	logic        next_stage_v;
	logic [63:0] stage_d;
	logic [63:0] next_stage_d;
	logic [63:0] next_data;
	logic        next_wr_take;
	logic        next_done;
	logic        next_mcheck;
	logic        busy;
	logic        eff_retry;
	logic        commit;
	logic        qual_grant;
	logic        room_ok;
	logic [2:0]  idx;
	logic        fifo_ready;
	logic [4:0]  fifo_level;

	// Free space is checked before grant so pushes never meet a full FIFO
	// Trade-off: reserving a whole line costs throughput but never stalls the bus
	// Write beats need no staging, since retry never applies to them
	assign room_ok = (fifo_level <= 5'(bdbt_pkg::FIFO_DEPTH) - bdbt_pkg::READ_ROOM);

	always_comb begin
		// Retry only counts on reads and in retry-enabled mode
		eff_retry    = !pins.retry_n && retry_mode && !is_write; // [R12]
		commit       = stage_v && !eff_retry; // [R10]
		idx          = cnt + 3'(commit); // [R22]
		qual_grant   = !pins.grant_n && pins.busy_in_n && pins.retry_n
		               && pins.addr_retry_n && (is_write || room_ok);
		next_state   = state;
		next_is_write = is_write;
		next_beats   = beats;
		next_cnt     = is_write ? cnt : idx; // [R22]
		next_stage_v = 1'b0;
		next_stage_d = stage_d;
		next_data    = data_o;
		next_wr_take = 1'b0;
		next_done    = 1'b0;
		next_mcheck  = 1'b0;
		// Read beats are staged one cycle so a retry can still cancel them
		if (!is_write && (state == bdbt_pkg::ST_DATA || state == bdbt_pkg::ST_TAIL)
		    && !pins.ack_n) begin
			next_stage_v = 1'b1;
			next_stage_d = data_s;
		end
		unique case (state)
			bdbt_pkg::ST_IDLE: begin
				// Only a request offered while ready is taken, so both sides agree
				if (pins.hard_reset_n && req_valid_i && req_ready_o) begin
					next_is_write = req_write_i;
					next_beats    = req_burst_i ? bdbt_pkg::BEATS_BURST
					                            : bdbt_pkg::BEATS_SINGLE; // [R20]
					next_state    = bdbt_pkg::ST_GRANT;
				end
			end
			bdbt_pkg::ST_GRANT: begin
				if (qual_grant) begin
					next_state = bdbt_pkg::ST_DATA; // [R21]
					next_cnt   = '0;
					if (is_write) begin
						next_data    = wr_data_i;
						next_wr_take = 1'b1;
					end
				end
			end
			bdbt_pkg::ST_DATA: begin
				if (!pins.err_n) begin
					next_state  = bdbt_pkg::ST_IDLE; // [R16]
					next_mcheck = 1'b1;
					next_done   = 1'b1;
				end else if (!pins.ack_n) begin
					if (is_write) begin
						if (cnt == beats - 3'h1) begin
							next_state = bdbt_pkg::ST_IDLE; // [R2]
							next_done  = 1'b1;
						end else begin
							next_cnt     = cnt + 3'h1; // [R1]
							next_data    = wr_data_i;
							next_wr_take = 1'b1;
						end
					end else if (idx == beats - 3'h1) begin
						next_state = bdbt_pkg::ST_TAIL; // [R2]
					end
				end
				// No acknowledge: stay here, each cycle is a wait state [R4]
			end
			bdbt_pkg::ST_TAIL: begin
				// Busy already dropped; a retry keeps this tenure alive
				if (!pins.err_n) begin
					next_state  = bdbt_pkg::ST_IDLE; // [R16]
					next_mcheck = 1'b1;
					next_done   = 1'b1;
				end else if (commit && pins.ack_n) begin
					next_state = bdbt_pkg::ST_IDLE; // [R11]
					next_done  = 1'b1;
				end
			end
		endcase
		// Hard reset abandons any tenure
		if (!pins.hard_reset_n) begin
			next_state   = bdbt_pkg::ST_IDLE;
			next_stage_v = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state         <= bdbt_pkg::ST_IDLE;
			is_write      <= 1'b0;
			beats         <= bdbt_pkg::BEATS_SINGLE;
			cnt           <= '0;
			stage_v       <= 1'b0;
			stage_d       <= '0;
			data_o        <= '0;
			wr_take_o     <= 1'b0;
			tenure_done_o <= 1'b0;
			mcheck_o      <= 1'b0;
			req_ready_o   <= 1'b0;
		end else begin
			state         <= next_state;
			is_write      <= next_is_write;
			beats         <= next_beats;
			cnt           <= next_cnt;
			stage_v       <= next_stage_v;
			stage_d       <= next_stage_d;
			data_o        <= next_data;
			wr_take_o     <= next_wr_take;
			tenure_done_o <= next_done;
			mcheck_o      <= next_mcheck;
			req_ready_o   <= (next_state == bdbt_pkg::ST_IDLE) && pins.hard_reset_n
			                 && !(state == bdbt_pkg::ST_IDLE && req_valid_i && req_ready_o);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers

	// Busy is driven high for one precharge cycle before release
	// Driving the line high first avoids waiting on a slow pull-up rise
	// Enable trails the busy level by one cycle, which gives that precharge
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			busy           <= 1'b0;
			dbus_busy_n_o  <= 1'b1;
			dbus_busy_oe_o <= 1'b0;
			data_oe_o      <= 1'b0;
		end else begin
			busy           <= (next_state == bdbt_pkg::ST_DATA); // [R21]
			dbus_busy_n_o  <= !(next_state == bdbt_pkg::ST_DATA);
			dbus_busy_oe_o <= (next_state == bdbt_pkg::ST_DATA) || busy;
			data_oe_o      <= (next_state == bdbt_pkg::ST_DATA) && next_is_write; // [R19]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data FIFO

	// A beat already confirmed is pushed even when an error follows [R17]
	bdbt_fifo #(
		.W  (bdbt_pkg::DATA_W),
		.D  (bdbt_pkg::FIFO_DEPTH),
		.AW (bdbt_pkg::FIFO_AW)
	) u_fifo (
		.mclk_i      (mclk_i),
		.rst_i       (rst_i),
		.in_valid_i  (commit && !is_write),
		.in_ready_o  (fifo_ready),
		.in_data_i   (stage_d),
		.out_valid_o (rd_valid_o),
		.out_ready_i (rd_ready_i),
		.out_data_o  (rd_data_o),
		.level_o     (fifo_level)
	);

	// Room is reserved at grant, so a refused push cannot happen
	logic unused_ready;
	assign unused_ready = fifo_ready;
endmodule

// ===== bdbt_pkg.sv
// Shared constants and carrier types for the data-beat termination block.
// Assumes one bus clock domain; pin levels arrive active low.
package bdbt_pkg;

	localparam int unsigned DATA_W     = 64;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned FIFO_AW    = 4;

	// Beat counts per transaction kind
	localparam logic [2:0] BEATS_SINGLE = 3'h1;
	localparam logic [2:0] BEATS_BURST  = 3'h4;

	// Free FIFO words needed before a read tenure may be granted
	localparam logic [FIFO_AW:0] READ_ROOM = 5'h4;

	// Values after reset
	localparam logic RETRY_MODE_RST = 1'b1;
	localparam logic PIN_IDLE_N     = 1'b1;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_GRANT = 2'b01,
		ST_DATA  = 2'b10,
		ST_TAIL  = 2'b11
	} bdbt_state_e;

	// Termination and arbitration pins, all active low
	typedef struct packed {
		logic ack_n;
		logic retry_n;
		logic err_n;
		logic grant_n;
		logic busy_in_n;
		logic addr_retry_n;
		logic hard_reset_n;
	} bdbt_pins_s;

endpackage

// ===== bdbt_fifo.sv
// Read-data FIFO between the bus side and the core side.
// Assumes both sides on mclk_i; full and empty are exact.
`timescale 1ns/1ps
module bdbt_fifo #(
	parameter int unsigned W  = 64,
	parameter int unsigned D  = 16,
	parameter int unsigned AW = 4
) (
	input  wire logic          mclk_i,
	input  wire logic          rst_i,
	input  wire logic          in_valid_i,
	output logic               in_ready_o,
	input  wire logic [W-1:0]  in_data_i,
	output logic               out_valid_o,
	input  wire logic          out_ready_i,
	output logic [W-1:0]       out_data_o,
	output logic [AW:0]        level_o
);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   level;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0]   next_level;
	logic          push;
	logic          pop;

	assign in_ready_o  = (level < (AW+1)'(D));
	assign out_valid_o = (level != '0);
	assign out_data_o  = mem[rd_ptr];
	assign level_o     = level;

	// Pointer and level update; a stalled drain lets the FIFO really fill
	always_comb begin
		push        = in_valid_i && in_ready_o;
		pop         = out_valid_o && out_ready_i;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_level  = level + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			level  <= next_level;
		end
	end

	// Storage carries no reset; only written words are ever read
	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
endmodule

// ===== bdbt_term_props.sv
// Property checker for bdbt_term, attached by the bind at the foot of this file.
// Assumes one bus clock, synchronous active-high reset, pins seen two cycles late.
`timescale 1ns/1ps
module bdbt_term_props (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic bus_error_ack_n_i,
	input wire logic dbus_grant_n_i,
	input wire logic req_valid_i,
	input wire logic req_ready_o,
	input wire logic wr_take_o,
	input wire logic data_oe_o,
	input wire logic dbus_busy_n_o,
	input wire logic dbus_busy_oe_o,
	input wire logic tenure_done_o,
	input wire logic mcheck_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////////////
	// Request taken, and busy precharge followed by release
	sequence s_take;
		req_valid_i && req_ready_o;
	endsequence
	sequence s_release;
		dbus_busy_oe_o ##1 !dbus_busy_oe_o;
	endsequence
	// Look-back of 2 to 4 cycles covers the two sync stages plus the output register
	a_done_pulse: assert property (tenure_done_o |=> !tenure_done_o)
		else $error("tenure done longer than one cycle");
	a_mcheck_pulse: assert property (mcheck_o |=> !mcheck_o)
		else $error("machine check longer than one cycle");
	a_mcheck_ends: assert property (mcheck_o |-> tenure_done_o && !data_oe_o)
		else $error("error did not end tenure and release data");
	a_mcheck_cause: assert property (mcheck_o |-> $past(!bus_error_ack_n_i, 2)
		|| $past(!bus_error_ack_n_i, 3) || $past(!bus_error_ack_n_i, 4))
		else $error("machine check without error acknowledge");
	a_busy_drive: assert property (!dbus_busy_n_o |-> dbus_busy_oe_o)
		else $error("busy asserted but not driven");
	a_busy_grant: assert property ($fell(dbus_busy_n_o) |-> $past(!dbus_grant_n_i, 2)
		|| $past(!dbus_grant_n_i, 3) || $past(!dbus_grant_n_i, 4))
		else $error("busy without grant");
	a_busy_release: assert property ($rose(dbus_busy_n_o) |-> s_release)
		else $error("busy not precharged then released");
	a_data_tenure: assert property (data_oe_o |-> !dbus_busy_n_o)
		else $error("data driven outside tenure");
	a_take_hold: assert property (s_take |=> !req_ready_o [*2])
		else $error("ready not dropped after take");
	a_wr_drive: assert property (wr_take_o |-> data_oe_o)
		else $error("write word taken while bus not driven");
endmodule

bind bdbt_term bdbt_term_props u_bdbt_term_props (.mclk_i, .rst_i, .bus_error_ack_n_i,
	.dbus_grant_n_i, .req_valid_i, .req_ready_o, .wr_take_o, .data_oe_o, .dbus_busy_n_o,
	.dbus_busy_oe_o, .tenure_done_o, .mcheck_o);

// ===== bdbt_target.sv
// Behavioural bus target: grants, acknowledges, retries and errors data beats.
// Assumes one tenure at a time; write acks spaced for the design's input sync delay.
`timescale 1ns/1ps
module bdbt_target (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        busy_n_i,
	input  wire logic        write_i,
	input  wire logic [2:0]  beats_i,
	input  wire logic [1:0]  wait_i,
	input  wire logic        rty_i,
	input  wire logic [1:0]  rty_beat_i,
	input  wire logic        err_i,
	input  wire logic [1:0]  err_beat_i,
	input  wire logic        strap_n_i,
	input  wire logic [63:0] base_i,
	output logic             ack_n_o = 1'b1,
	output logic             retry_n_o = 1'b1,
	output logic             err_n_o = 1'b1,
	output logic             grant_n_o = 1'b1,
	output logic [63:0]      rdata_o = 64'h0
);
	logic [2:0] st;
	logic [2:0] beat;
	logic [2:0] wc;
	logic [2:0] gap;
	logic       hit;
	assign gap = {1'b0, wait_i} + (write_i ? 3'h4 : 3'h0);
	assign hit = rty_i && beat[1:0] == rty_beat_i;
	////////////////////////////////////////////////////////////////////////////////
	// Ack and error default to negated, retry to the strap level; released data lines toggle rather than hold a value
	always @(posedge mclk_i) begin
		ack_n_o <= 1'b1;
		err_n_o <= 1'b1;
		retry_n_o <= strap_n_i;
		rdata_o <= ~rdata_o;
		if (rst_i) begin
			st <= 3'h0;
			grant_n_o <= 1'b1;
		end else case (st)
			3'h0: begin
				grant_n_o <= 1'b0;
				if (!busy_n_i) begin
					grant_n_o <= 1'b1;
					beat <= 3'h0;
					wc <= gap + 3'h1;
					st <= 3'h1;
				end
			end
			3'h1: if (wc != 3'h0) begin
				wc <= wc - 3'h1;
			end else if (err_i && beat[1:0] == err_beat_i) begin
				err_n_o <= 1'b0;
				st <= 3'h4;
			end else begin
				ack_n_o <= 1'b0;
				rdata_o <= (hit && !write_i) ? ~(base_i ^ {61'h0, beat}) : base_i ^ {61'h0, beat};
				beat <= (hit && !write_i) ? beat : beat + 3'h1;
				wc <= gap;
				st <= hit ? 3'h2 : (beat + 3'h1 == beats_i ? 3'h4 : 3'h1);
			end
			3'h2: begin
				retry_n_o <= 1'b0;
				st <= write_i ? (beat == beats_i ? 3'h4 : 3'h1) : 3'h3;
			end
			3'h3: begin
				retry_n_o <= 1'b0;
				ack_n_o <= 1'b0;
				rdata_o <= base_i ^ {61'h0, beat};
				beat <= beat + 3'h1;
				st <= beat + 3'h1 == beats_i ? 3'h4 : 3'h1;
			end
			default: if (busy_n_i) st <= 3'h0;
		endcase
	end
endmodule

// ===== bdbt_term_tb.sv
// Self-checking bench for bdbt_term against the behavioural target.
// Assumes bdbt_target.sv and the bound checker; random stimulus from a fixed seed.
`timescale 1ns/1ps
module bdbt_term_tb;
	logic        mclk_i = 1'b0, rst_i = 1'b1, hard_reset_n_i = 1'b0, rd_ready_i = 1'b0;
	logic        req_valid_i = 1'b0, req_write_i = 1'b0, req_burst_i = 1'b0;
	logic        transfer_ack_n_i, beat_retry_in_n_i, bus_error_ack_n_i, dbus_grant_n_i;
	logic        req_ready_o, wr_take_o, rd_valid_o, tenure_done_o, mcheck_o, data_oe_o;
	logic        dbus_busy_n_o, dbus_busy_oe_o, no_retry_mode_o, dbus_busy_n_i;
	logic [63:0] data_i, data_o, rd_data_o, wr_data_i, tgt_data, base = 64'h0, wbase = 64'h0;
	logic [2:0]  beats = 3'h1, wi = 3'h0, wa = 3'h0;
	logic [1:0]  wt = 2'h0, rbeat = 2'h0, ebeat = 2'h0;
	logic        wr = 1'b0, rty = 1'b0, er = 1'b0, strap_n = 1'b1, stall = 1'b0;
	logic [63:0] exp_q[$];
	int          fails = 0, n_compared = 0, n_mcheck = 0, seed = 52, r;
	// Shared wires resolved from every driver; busy has a pull-up
	assign data_i = data_oe_o ? data_o : tgt_data;
	assign dbus_busy_n_i = dbus_busy_oe_o ? dbus_busy_n_o : 1'b1;
	assign wr_data_i = wbase ^ {61'h0, wi};
	always #20 mclk_i = ~mclk_i;
	bdbt_term u_bdbt_term (.mclk_i, .rst_i, .transfer_ack_n_i, .beat_retry_in_n_i,
		.bus_error_ack_n_i, .dbus_grant_n_i, .dbus_busy_n_i, .addr_retry_n_i(1'b1),
		.hard_reset_n_i, .data_i, .data_o, .data_oe_o, .dbus_busy_n_o, .dbus_busy_oe_o,
		.req_valid_i, .req_write_i, .req_burst_i, .req_ready_o, .wr_data_i, .wr_take_o,
		.rd_valid_o, .rd_ready_i, .rd_data_o, .tenure_done_o, .mcheck_o, .no_retry_mode_o);
	bdbt_target u_bdbt_target (.mclk_i, .rst_i, .busy_n_i(dbus_busy_n_i), .write_i(wr),
		.beats_i(beats), .wait_i(wt), .rty_i(rty), .rty_beat_i(rbeat), .err_i(er),
		.err_beat_i(ebeat), .strap_n_i(strap_n), .base_i(base), .ack_n_o(transfer_ack_n_i),
		.retry_n_o(beat_retry_in_n_i), .err_n_o(bus_error_ack_n_i),
		.grant_n_o(dbus_grant_n_i), .rdata_o(tgt_data));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (fails == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Bounded wait; running out is a mismatch and ends the run
	task automatic wait_hi(ref logic sig);
		for (int k = 0; k < 600 && sig !== 1'b1; k++) @(posedge mclk_i);
		if (sig !== 1'b1) begin
			fails++;
			end_sim();
		end
	endtask
	task automatic drain();
		for (int k = 0; k < 600 && exp_q.size() > 0; k++) @(posedge mclk_i);
		check("words left", 64'(exp_q.size()), 64'h0);
		if (exp_q.size() > 0) end_sim();
	endtask
	// Beat i of a transfer carries its base word with the beat number folded in
	function automatic logic [63:0] beat_word(input logic [63:0] b, input int i);
		return b ^ 64'(i);
	endfunction
	// One tenure; reads queue the words expected out of the buffer
	task automatic run(input logic w, input logic [2:0] nb, input logic ry, input logic e,
			input int hold);
		int n;
		int m0;
		int rr;
		rr = $random(seed);
		m0 = n_mcheck;
		n = e ? int'(rr[5:4] & {2{nb[2]}}) : int'(nb);
		@(posedge mclk_i);
		wr <= w;
		beats <= nb;
		rty <= ry;
		er <= e;
		wt <= rr[1:0];
		rbeat <= rr[3:2] & {2{nb[2]}};
		ebeat <= rr[5:4] & {2{nb[2]}};
		base <= {rr, ~rr};
		wbase <= {~rr, rr};
		wi <= 3'h0;
		wa <= 3'h0;
		req_write_i <= w;
		req_burst_i <= nb[2];
		req_valid_i <= 1'b1;
		if (!w) for (int i = 0; i < n; i++) exp_q.push_back(beat_word({rr, ~rr}, i));
		@(posedge mclk_i);
		wait_hi(req_ready_o);
		req_valid_i <= 1'b0;
		repeat (hold) begin
			@(posedge mclk_i);
			check("busy while full", 64'(dbus_busy_n_o), 64'h1);
		end
		if (hold > 0) stall <= 1'b0;
		wait_hi(tenure_done_o);
		@(posedge mclk_i);
		check("mcheck count", 64'(n_mcheck), 64'(m0 + int'(e)));
	endtask
	// Write beats checked on the wire at each ack; read words checked as they leave
	always @(posedge mclk_i) begin
		if (wr_take_o === 1'b1) wi <= wi + 3'h1;
		if (mcheck_o === 1'b1) n_mcheck <= n_mcheck + 1;
		if (transfer_ack_n_i === 1'b0 && data_oe_o === 1'b1) begin
			check("write beat", data_i, beat_word(wbase, int'(wa)));
			wa <= wa + 3'h1;
		end
		if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1)
			check("read word", rd_data_o, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
		r = $random(seed);
		rd_ready_i <= !stall && r[0];
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		hard_reset_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		check("retry mode", 64'(no_retry_mode_o), 64'h0);
		// Random mix with retries on reads and writes alike, then errors mid-burst
		repeat (16) begin
			r = $random(seed);
			run(r[0], r[1] ? 3'h4 : 3'h1, r[2], 1'b0, 0);
		end
		run(1'b0, 3'h4, 1'b0, 1'b1, 0);
		run(1'b1, 3'h4, 1'b1, 1'b1, 0);
		drain();
		// Fill the buffer with the consumer stalled; the fifth burst must wait
		stall <= 1'b1;
		repeat (4) run(1'b0, 3'h4, 1'b0, 1'b0, 0);
		run(1'b0, 3'h4, 1'b0, 1'b0, 30);
		drain();
		// Strap no-retry mode through a hard reset
		hard_reset_n_i <= 1'b0;
		strap_n <= 1'b0;
		repeat (6) @(posedge mclk_i);
		hard_reset_n_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		strap_n <= 1'b1;
		check("no-retry mode", 64'(no_retry_mode_o), 64'h1);
		run(1'b0, 3'h4, 1'b0, 1'b0, 0);
		drain();
		end_sim();
	end
endmodule
